// file: inc/frame_crc32_defines.vh
// Constants shared by the frame check generator and its update network.
// Assumes it is included by bare name from files under rtl/.
`ifndef FRAME_CRC32_DEFINES_VH
`define FRAME_CRC32_DEFINES_VH

// Generator polynomial, top term implied, and the seed loaded at frame start.
`define CRC_POLY            32'h04c11db7
`define CRC_SEED            32'h52325032
`define CRC_WIDTH           32

// Frame size limits in bytes, and the bytes per dword.
`define CRC_GUARANTEE_BYTES 16384
`define CRC_PAYLOAD_BYTES   8192
`define CRC_OVERHEAD_BYTES  64
`define CRC_BYTES_PER_WORD  4

// Width of the dword counter, enough to pass the largest limit.
`define CRC_COUNT_WIDTH     13

`endif

// file: rtl/crc32_dword_update.v
// Combinational update of the 32-bit remainder by one whole dword.
// Assumes the caller registers the result; no state is held here.
`include "frame_crc32_defines.vh"
`default_nettype none

module crc32_dword_update (
   // Current remainder and incoming content dword.
   input  wire [31:0] remainder,
   input  wire [31:0] dataWord,
   // Remainder after the dword is folded in.
   output reg  [31:0] nextRemainder
);

   reg [31:0] work;
   integer    i;

   // The dword is added to the remainder first, then the feedback network acts
   // on the sum; the loop unrolls into a flat XOR network.
   always @* begin
      work = remainder ^ dataWord;
      for (i = 0; i < `CRC_WIDTH; i = i + 1) begin
         if (work[31]) begin
            work = {work[30:0], 1'b0} ^ `CRC_POLY;
         end else begin
            work = {work[30:0], 1'b0};
         end
      end
      nextRemainder = work;
   end

endmodule // crc32_dword_update

`default_nettype wire

// file: rtl/frame_crc32_generator.v
// Frame check generator and checker, one dword per clock.
// Assumes framing logic on the same clock drives the strobes, one request each.
//
// Notes on behaviour
// - Polynomial x32+x26+x23+x22+x16+...+x+1.
// - Fold one full dword per update, parallel.
// - Check dword follows last content, precedes end.
// - Detection guaranteed only up to 16384 bytes.
// - At most 8192 payload plus 64 overhead bytes.
// - Load seed 0x52325032 at every frame start.
// - XOR dword into remainder, then feedback network.
`include "frame_crc32_defines.vh"
`default_nettype none

module frame_crc32_generator (
   // Clock, reset and clock enable.
   input  wire        clk,
   input  wire        rst,
   input  wire        clkEn,
   // Frame control from the framing logic.
   input  wire        frameStart,
   input  wire        wordValid,
   input  wire [31:0] wordIn,
   input  wire        sendCheck,
   input  wire        rxCheckValid,
   input  wire [31:0] rxCheckWord,
   // Transmit check dword.
   output reg         checkValid,
   output reg  [31:0] checkWord,
   // Receive verdict.
   output reg         crcMismatch,
   output reg         crcMatch,
   // Frame state and size flags.
   output reg         inFrame,
   output reg         overPayloadLimit,
   output reg         overGuaranteeLimit
);

   ////////////////////////////////////////////////////////////////////////////
   localparam [1:0] IDLE  = 2'b01;
   localparam [1:0] ACCUM = 2'b10;

   localparam integer PAYLOAD_WORDS_I =
      (`CRC_PAYLOAD_BYTES + `CRC_OVERHEAD_BYTES) / `CRC_BYTES_PER_WORD;
   localparam integer GUARANTEE_WORDS_I = `CRC_GUARANTEE_BYTES / `CRC_BYTES_PER_WORD;
   localparam [`CRC_COUNT_WIDTH-1:0] PAYLOAD_WORDS   = PAYLOAD_WORDS_I[`CRC_COUNT_WIDTH-1:0];
   localparam [`CRC_COUNT_WIDTH-1:0] GUARANTEE_WORDS =
      GUARANTEE_WORDS_I[`CRC_COUNT_WIDTH-1:0];
   localparam [`CRC_COUNT_WIDTH-1:0] COUNT_MAX = {`CRC_COUNT_WIDTH{1'b1}};
   localparam [`CRC_COUNT_WIDTH-1:0] COUNT_ONE = {{(`CRC_COUNT_WIDTH-1){1'b0}}, 1'b1};

   ////////////////////////////////////////////////////////////////////////////
   reg  [1:0]                  state;
   reg  [1:0]                  next_state;
   reg  [31:0]                 remainder;
   reg  [`CRC_COUNT_WIDTH-1:0] wordCount;
   reg  [`CRC_COUNT_WIDTH-1:0] next_wordCount;
   wire [31:0]                 updateBase;
   wire [31:0]                 updated;
   wire                        foldWord;
   wire                        closeFrame;

   // A start with a word in the same cycle folds that word onto the seed.
   assign updateBase = frameStart ? `CRC_SEED : remainder;
   assign foldWord   = wordValid && (frameStart || (state == ACCUM));
   assign closeFrame = (sendCheck || rxCheckValid) && (state == ACCUM) && !frameStart;

   crc32_dword_update u_update (
      .remainder     (updateBase),
      .dataWord      (wordIn),
      .nextRemainder (updated)
   );

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      next_state = state;
      case (state)
         IDLE: begin
            if (frameStart) begin
               next_state = ACCUM;
            end
         end
         ACCUM: begin
            if (frameStart) begin
               next_state = ACCUM;
            end else if (closeFrame) begin
               next_state = IDLE;
            end
         end
         default: begin
            next_state = IDLE;
         end
      endcase
   end

   // Dword count saturates so a runaway frame cannot wrap below the limits.
   always @* begin
      if (frameStart) begin
         next_wordCount = wordValid ? COUNT_ONE : {`CRC_COUNT_WIDTH{1'b0}};
      end else if (foldWord && (wordCount != COUNT_MAX)) begin
         next_wordCount = wordCount + COUNT_ONE;
      end else begin
         next_wordCount = wordCount;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state              <= IDLE;
         remainder          <= `CRC_SEED;
         wordCount          <= {`CRC_COUNT_WIDTH{1'b0}};
         checkValid         <= 1'b0;
         checkWord          <= 32'h00000000;
         crcMismatch        <= 1'b0;
         crcMatch           <= 1'b0;
         inFrame            <= 1'b0;
         overPayloadLimit   <= 1'b0;
         overGuaranteeLimit <= 1'b0;
      end else if (clkEn) begin
         state     <= next_state;
         wordCount <= next_wordCount;
         inFrame   <= (next_state == ACCUM);
         if (foldWord) begin
            remainder <= updated;
         end else if (frameStart) begin
            remainder <= `CRC_SEED;
         end
         // Check dword is issued the cycle after the last content dword is
         // folded, so the framing logic places it right before end of frame.
         checkValid <= closeFrame && sendCheck;
         if (closeFrame && sendCheck) begin
            checkWord <= remainder;
         end
         crcMismatch <= closeFrame && !sendCheck && (rxCheckWord != remainder);
         crcMatch    <= closeFrame && !sendCheck && (rxCheckWord == remainder);
         // Size flags hold for the frame and clear at the next start.
         overPayloadLimit   <= (next_wordCount > PAYLOAD_WORDS) ||
                               (overPayloadLimit && !frameStart);
         overGuaranteeLimit <= (next_wordCount > GUARANTEE_WORDS) ||
                               (overGuaranteeLimit && !frameStart);
      end
   end

endmodule // frame_crc32_generator

`default_nettype wire

// file: verif/frame_crc32_checker.sv
// Port assertions for the frame check block.
// Assumes one clock and tie-free binding to frame_crc32_generator.
`default_nettype none
module frame_crc32_checker (
   input wire logic clk, rst, clkEn, frameStart, wordValid, sendCheck, rxCheckValid,
   input wire logic [31:0] wordIn, rxCheckWord, checkWord,
   input wire logic checkValid, crcMismatch, crcMatch, inFrame,
   input wire logic overPayloadLimit, overGuaranteeLimit);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire close = clkEn && inFrame && !frameStart;
   property p_tx; close && sendCheck |=> checkValid && !inFrame; endproperty
   a_tx: assert property (p_tx) else $error("check dword missing");
   property p_rx; close && rxCheckValid && !sendCheck |=> crcMatch != crcMismatch; endproperty
   a_rx: assert property (p_rx) else $error("receive verdict missing");
   property p_pulse; clkEn && crcMismatch |=> !crcMismatch || $past(rxCheckValid); endproperty
   a_pulse: assert property (p_pulse) else $error("mismatch flag too long");
   property p_seed;
      clkEn && frameStart && !wordValid ##1 close && sendCheck && !wordValid
      |=> checkWord == 32'h52325032;
   endproperty
   a_seed: assert property (p_seed) else $error("empty frame not seed");
   property p_start; clkEn && frameStart |=> inFrame && !overPayloadLimit; endproperty
   a_start: assert property (p_start) else $error("frame start ignored");
   property p_lim; overGuaranteeLimit |-> overPayloadLimit; endproperty
   a_lim: assert property (p_lim) else $error("limit flags disagree");
   property p_only; $rose(checkValid) |-> $past(sendCheck); endproperty
   a_only: assert property (p_only) else $error("check dword unasked");
   property p_idle; !inFrame && !frameStart && clkEn |=> !inFrame; endproperty
   a_idle: assert property (p_idle) else $error("frame opened unasked");
   c_tx: cover property (checkValid);
   c_ok: cover property (crcMatch);
   c_bad: cover property (crcMismatch);
endmodule // frame_crc32_checker
bind frame_crc32_generator frame_crc32_checker chk_u (.*);
`default_nettype wire

// file: verif/link_framer_model.sv
// Framing logic model: start, n content dwords, then one close.
// Assumes go is a one-cycle pulse while no frame is being sent.
`default_nettype none
module link_framer_model (
   input  wire logic        clk, go, rx,
   input  wire logic [15:0] n,
   input  wire logic [31:0] chk,
   output var logic         frameStart = 0, wordValid = 0, sendCheck = 0, rxCheckValid = 0,
   output var logic [31:0]  wordIn = 0, rxCheckWord = 0);
   timeunit 1ns; timeprecision 1ns;
   logic [15:0] i = 0;
   logic       busy = 0;
   always @(posedge clk) begin
      {frameStart, wordValid, sendCheck, rxCheckValid} <= 4'h0;
      // Idle data lines keep changing so stale values never look valid.
      wordIn <= ~wordIn;
      rxCheckWord <= ~rxCheckWord;
      if (go) begin
         frameStart <= 1; busy <= 1; i <= 0;
      end else if (busy && i < n) begin
         wordValid <= 1; wordIn <= {4{i[7:0]}}; i <= i + 1;
      end else if (busy) begin
         busy <= 0; sendCheck <= !rx; rxCheckValid <= rx; rxCheckWord <= chk;
      end
   end
endmodule // link_framer_model
`default_nettype wire

// file: verif/test_frame_crc32_generator.sv
// Self-checking bench for the frame check block.
// Assumes the framing model feeds all frame inputs.
`default_nettype none
module test_frame_crc32_generator;
   timeunit 1ns; timeprecision 1ns;
   logic clk = 0, rst = 1, clkEn = 1, go = 0, rx = 0, checkValid, crcMismatch, crcMatch;
   logic frameStart, wordValid, sendCheck, rxCheckValid, inFrame;
   logic overPayloadLimit, overGuaranteeLimit;
   logic [15:0] n = 0;
   logic [31:0] chk = 0, wordIn, rxCheckWord, checkWord;
   int mismatches = 0, comparisons = 0;
   always #5 clk = ~clk;
   link_framer_model lf_u (.clk, .go, .rx, .n, .chk, .frameStart, .wordValid, .sendCheck,
      .rxCheckValid, .wordIn, .rxCheckWord);
   frame_crc32_generator dut_u (.clk, .rst, .clkEn, .frameStart, .wordValid, .wordIn,
      .sendCheck, .rxCheckValid, .rxCheckWord, .checkValid, .checkWord, .crcMismatch,
      .crcMatch, .inFrame, .overPayloadLimit, .overGuaranteeLimit);
   function automatic logic [31:0] crc(input int k);
      logic [31:0] c = 32'h52325032;
      for (int j = 0; j < k; j++) begin
         c ^= {4{j[7:0]}};
         repeat (32) c = c[31] ? (c << 1) ^ 32'h04c11db7 : c << 1;
      end
      return c;
   endfunction
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Frozen block must ignore a whole frame sent while clkEn is low.
   task automatic freeze;
      @(posedge clk) begin clkEn <= 0; go <= 1; n <= 16'd2; rx <= 0; end
      @(posedge clk) go <= 0;
      repeat (6) @(posedge clk);
      #1 cmp("frozen frame", 0, {30'h0, inFrame, checkValid});
      @(posedge clk) clkEn <= 1;
   endtask
   task automatic frame(input logic [15:0] k, input logic r, input logic [31:0] c);
      @(posedge clk) begin go <= 1; n <= k; rx <= r; chk <= c; end
      @(posedge clk) go <= 0;
      for (int w = 0; w < 5000 && (checkValid | crcMatch | crcMismatch) !== 1; w++)
         @(posedge clk) #1;
      if ((checkValid | crcMatch | crcMismatch) !== 1) begin mismatches++; give_verdict; end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      frame(0, 0, 0); cmp("seed", 32'h52325032, checkWord);
      frame(9, 0, 0); cmp("check", crc(9), checkWord);
      cmp("frame open", 0, {31'h0, inFrame});
      freeze;
      frame(16'd2065, 0, 0); cmp("long check", crc(2065), checkWord);
      cmp("payload limit", 1, {31'h0, overPayloadLimit});
      cmp("guarantee limit", 0, {31'h0, overGuaranteeLimit});
      frame(16'd4097, 0, 0); cmp("guarantee limit", 1, {31'h0, overGuaranteeLimit});
      frame(3, 1, crc(3)); cmp("match", 1, {31'h0, crcMatch});
      cmp("limits cleared", 0, {30'h0, overPayloadLimit, overGuaranteeLimit});
      frame(3, 1, crc(3) ^ 32'h1); cmp("mismatch", 1, {31'h0, crcMismatch});
      give_verdict;
   end
endmodule // test_frame_crc32_generator
`default_nettype wire
